/* src/eeprom_cmd_pkg.sv */
// shared constants and types for the serial eeprom command block
package eeprom_cmd_pkg;
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned OP_TIMEOUT_MS = 30;
   localparam int unsigned OP_TIMEOUT_CYC = OP_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned SK_HALF_NS = 1000;
   localparam int unsigned SK_HALF_CYC = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam logic [11:0] CMD_OFFSET = 12'hb0;
   localparam logic [11:0] DATA_OFFSET = 12'hb4;

   localparam int unsigned BUSY_BIT = 31;
   localparam int unsigned CODE_MSB = 30;
   localparam int unsigned CODE_LSB = 28;
   localparam int unsigned TIMEOUT_BIT = 9;
   localparam int unsigned LOADED_BIT = 8;
   localparam logic [7:0] ADDR_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // first stored byte marks a programmed memory; value is arbitrary
   localparam logic [7:0] VALID_SIGNATURE = 8'ha5;
   localparam logic [2:0] LAST_RELOAD_IDX = 3'h6;

   localparam int unsigned FRAME_W = 19;
   localparam logic [4:0] SHORT_BITS = 5'h0b;
   localparam logic [4:0] LONG_BITS = 5'h13;
   localparam logic [1:0] OP_EXT = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_ERASE = 2'h3;
   localparam logic [7:0] EXT_DISABLE = 8'h00;
   localparam logic [7:0] EXT_FILL = 8'h40;
   localparam logic [7:0] EXT_CLEAR = 8'h80;
   localparam logic [7:0] EXT_ENABLE = 8'hc0;

   typedef enum logic [2:0] {
      readCmd, eraseWriteDisableCmd, eraseWriteEnableCmd, writeCmd,
      fillAllCmd, eraseCmd, clearAllCmd, reloadCmd
   } command_type;

   typedef struct packed {
      logic chipSelect;
      logic serialClock;
      logic serialDataOut;
      logic serialDataOe;
   } wire_out_type;
endpackage

/* src/eeprom_timeout_timer.sv */
// counts how long a wait for the memory's ready answer has lasted
`timescale 1ns/1ps
module eeprom_timeout_timer #(
   parameter int unsigned CYCLES = eeprom_cmd_pkg::OP_TIMEOUT_CYC
) (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic run,
   output logic      expired
);
   localparam int unsigned W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);
   logic [W-1:0] count;
   wire          atLast = (count == LAST);

   // restarts whenever run drops, so each wait gets the full window
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= '0;
         expired <= 1'b0;
      end else begin
         count <= (run && !atLast) ? count + W'(1) : '0;
         expired <= run && atLast && !expired;
      end
   end
endmodule

/* src/eeprom_wire_engine.sv */
// three-wire frame shifter with optional byte read and ready wait
`timescale 1ns/1ps
module eeprom_wire_engine #(
   parameter int unsigned HALF = eeprom_cmd_pkg::SK_HALF_CYC,
   parameter int unsigned FW   = eeprom_cmd_pkg::FRAME_W
) (
   input  wire logic                         clk,
   input  wire logic                         rst_b,
   input  wire logic                         start,
   input  wire logic [FW-1:0]                frame,
   input  wire logic [4:0]                   outBits,
   input  wire logic                         readByte,
   input  wire logic                         waitReady,
   input  wire logic                         abort,
   input  wire logic                         dataIn,
   output eeprom_cmd_pkg::wire_out_type      pins,
   output logic                              waiting,
   output logic                              done,
   output logic [7:0]                        readData
);
   typedef enum {eIdle, eShift, eRead, eGap, eWait} eng_type;
   eng_type         state;
   logic [FW-1:0]   shifter;
   logic [4:0]      bitCnt;
   logic            doRead;
   logic            doWait;
   logic [$clog2(HALF+1)-1:0] div;
   wire             tick = (div == '0);
   wire             lastBit = (bitCnt == 5'h01);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= eIdle;
         pins <= '0;
         shifter <= '0;
         bitCnt <= '0;
         doRead <= 1'b0;
         doWait <= 1'b0;
         div <= '0;
         waiting <= 1'b0;
         done <= 1'b0;
         readData <= '0;
      end else begin
         done <= 1'b0;
         div <= (tick || state == eIdle) ? ($bits(div))'(HALF - 1) : div - 1'b1;
         case (state)
            eIdle: if (start) begin
               state <= eShift;
               shifter <= frame;
               bitCnt <= outBits;
               doRead <= readByte;
               doWait <= waitReady;
               pins <= '{chipSelect: 1'b1, serialClock: 1'b0,
                         serialDataOut: frame[FW-1], serialDataOe: 1'b1};
            end
            eShift: if (tick) begin
               pins.serialClock <= !pins.serialClock;
               if (pins.serialClock) begin
                  shifter <= shifter << 1;
                  pins.serialDataOut <= shifter[FW-2];
                  bitCnt <= bitCnt - 5'h01;
                  if (lastBit) begin
                     pins.serialDataOe <= 1'b0;
                     bitCnt <= 5'h08;
                     state <= doRead ? eRead : (doWait ? eGap : eIdle);
                     if (!doRead && !doWait) begin
                        pins.chipSelect <= 1'b0;
                        done <= 1'b1;
                     end
                  end
               end
            end
            eRead: if (tick) begin
               pins.serialClock <= !pins.serialClock;
               if (pins.serialClock) begin
                  readData <= {readData[6:0], dataIn};
                  bitCnt <= bitCnt - 5'h01;
                  if (lastBit) begin
                     pins.chipSelect <= 1'b0;
                     done <= 1'b1;
                     state <= eIdle;
                  end
               end
            end
            // select drops for HALF-1 clocks, one short of a half period, to start the busy poll
            eGap: begin
               pins.chipSelect <= tick ? pins.chipSelect : 1'b0;
               if (tick && !pins.chipSelect) begin
                  pins.chipSelect <= 1'b1;
                  waiting <= 1'b1;
                  state <= eWait;
               end
            end
            eWait: if (dataIn || abort) begin
               pins.chipSelect <= 1'b0;
               waiting <= 1'b0;
               done <= 1'b1;
               state <= eIdle;
            end
            default: state <= eIdle;
         endcase
      end
   end
endmodule

/* src/serial_eeprom_command_status.sv */
// apb command and status front end of the serial eeprom controller
//
// Operation
// (RULE1) no ready answer within 30 ms: abandon, go idle, set time-out flag
// (RULE2) data line held high with no memory: no time-out, busy clears at sequence end
// (RULE3) with line low only erase, clear-all, write, fill-all may time out
// (RULE4) address-loaded flag set after valid memory and full station address load
// (RULE5) 8-bit byte address in low command bits selects location, resets to zero
// (RULE6) memory keeps erase/write enabled until disable command or power cycle
// (RULE7) separate 8-bit byte buffer holds read or write byte, resets to zero
// (RULE8) status flags stay set until software writes one; zero leaves them
`timescale 1ns/1ps
module serial_eeprom_command_status #(
   parameter int unsigned TIMEOUT_CYCLES = eeprom_cmd_pkg::OP_TIMEOUT_CYC,
   parameter int unsigned SK_HALF        = eeprom_cmd_pkg::SK_HALF_CYC
) (
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [11:0]              paddr,
   input  wire logic [31:0]              pwdata,
   output logic                          pready,
   output logic [31:0]                   prdata,
   output logic                          pslverr,
   input  wire logic                     serialDataIn,
   output eeprom_cmd_pkg::wire_out_type  serialPins,
   output logic [47:0]                   stationAddr
);
   typedef enum {sIdle, sLaunch, sRun} ctl_type;
   ctl_type                     state;
   eeprom_cmd_pkg::command_type cmdCode;
   logic [7:0]                  memAddr;
   logic [7:0]                  byteBuf;
   logic                        timeoutFlag;
   logic                        loadedFlag;
   logic                        busyFlag;
   logic                        inReload;
   logic [2:0]                  idx;
   logic                        engWaiting;
   logic                        engDone;
   logic [7:0]                  engData;
   logic                        timerExpired;

   // apb decode; one wait state so read data comes from a flop
   wire        access   = psel && penable && pready;
   wire        wrAccess = access && pwrite;
   wire        hitCmd   = (paddr == eeprom_cmd_pkg::CMD_OFFSET);
   wire        hitData  = (paddr == eeprom_cmd_pkg::DATA_OFFSET);
   wire        wrCmd    = wrAccess && hitCmd;
   wire        wrData   = wrAccess && hitData;
   wire        launchSw = wrCmd && !busyFlag && pwdata[eeprom_cmd_pkg::BUSY_BIT];
   wire [31:0] cmdView  = {busyFlag, cmdCode, 18'h0, timeoutFlag, loadedFlag, memAddr};
   wire [31:0] rdMux    = hitCmd ? cmdView : (hitData ? {24'h0, byteBuf} : 32'h0);

   // address and byte buffer ignore bus writes while a command runs; a read loads the buffer at its end [RULE5] [RULE7]
   wire        loadAddr = wrCmd && !busyFlag;
   wire        loadData = wrData && !busyFlag;
   wire        clrTimeout = wrCmd && pwdata[eeprom_cmd_pkg::TIMEOUT_BIT];
   wire        clrLoaded  = wrCmd && pwdata[eeprom_cmd_pkg::LOADED_BIT];

   // frame build: start bit, opcode, address, data
   wire [7:0]  frameAddr = inReload ? {5'h00, idx} : memAddr;
   logic [1:0] opBits;
   logic [7:0] addrBits;
   always_comb begin
      opBits = eeprom_cmd_pkg::OP_EXT;
      addrBits = frameAddr;
      case (inReload ? eeprom_cmd_pkg::readCmd : cmdCode)
         eeprom_cmd_pkg::readCmd:              opBits = eeprom_cmd_pkg::OP_READ;
         eeprom_cmd_pkg::writeCmd:             opBits = eeprom_cmd_pkg::OP_WRITE;
         eeprom_cmd_pkg::eraseCmd:             opBits = eeprom_cmd_pkg::OP_ERASE;
         eeprom_cmd_pkg::eraseWriteEnableCmd:  addrBits = eeprom_cmd_pkg::EXT_ENABLE;
         eeprom_cmd_pkg::eraseWriteDisableCmd: addrBits = eeprom_cmd_pkg::EXT_DISABLE;
         eeprom_cmd_pkg::fillAllCmd:           addrBits = eeprom_cmd_pkg::EXT_FILL;
         eeprom_cmd_pkg::clearAllCmd:          addrBits = eeprom_cmd_pkg::EXT_CLEAR;
         default:                              opBits = eeprom_cmd_pkg::OP_READ;
      endcase
   end
   wire isWrite  = !inReload && (cmdCode == eeprom_cmd_pkg::writeCmd);
   wire isFill   = !inReload && (cmdCode == eeprom_cmd_pkg::fillAllCmd);
   wire isErase  = !inReload && (cmdCode == eeprom_cmd_pkg::eraseCmd);
   wire isClear  = !inReload && (cmdCode == eeprom_cmd_pkg::clearAllCmd);
   wire isRead   = inReload || (cmdCode == eeprom_cmd_pkg::readCmd);
   // only the programming commands poll for ready, so only they can time out [RULE3]
   wire needWait = isWrite || isFill || isErase || isClear;
   wire hasData  = isWrite || isFill;
   wire [eeprom_cmd_pkg::FRAME_W-1:0] frame = {1'b1, opBits, addrBits, byteBuf};
   wire [4:0]  nBits = hasData ? eeprom_cmd_pkg::LONG_BITS : eeprom_cmd_pkg::SHORT_BITS;
   wire        reloadLast = (idx == eeprom_cmd_pkg::LAST_RELOAD_IDX);
   wire        sigBad = (idx == 3'h0) && (engData != eeprom_cmd_pkg::VALID_SIGNATURE);
   wire        reloadEnd = inReload && (reloadLast || sigBad);

   eeprom_wire_engine #(
      .HALF (SK_HALF),
      .FW   (eeprom_cmd_pkg::FRAME_W)
   ) engine (
      .clk       (clk),
      .rst_b     (rst_b),
      .start     (state == sLaunch),
      .frame     (frame),
      .outBits   (nBits),
      .readByte  (isRead),
      .waitReady (needWait),
      .abort     (timerExpired),
      .dataIn    (serialDataIn),
      .pins      (serialPins),
      .waiting   (engWaiting),
      .done      (engDone),
      .readData  (engData)
   );

   // the window only runs while the memory is being polled for ready [RULE1]
   eeprom_timeout_timer #(
      .CYCLES (TIMEOUT_CYCLES)
   ) timer (
      .clk     (clk),
      .rst_b   (rst_b),
      .run     (engWaiting),
      .expired (timerExpired)
   );

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         prdata <= (psel && penable && !pready && !pwrite) ? rdMux : 32'h0;
         pslverr <= psel && penable && !pready && !hitCmd && !hitData;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         memAddr <= eeprom_cmd_pkg::ADDR_RESET;
         byteBuf <= eeprom_cmd_pkg::DATA_RESET;
         cmdCode <= eeprom_cmd_pkg::readCmd;
      end else begin
         if (loadAddr) begin
            memAddr <= pwdata[7:0]; // [RULE5]
            cmdCode <= eeprom_cmd_pkg::command_type'(
               pwdata[eeprom_cmd_pkg::CODE_MSB:eeprom_cmd_pkg::CODE_LSB]);
         end
         if (loadData) begin
            byteBuf <= pwdata[7:0]; // [RULE7]
         end else if (engDone && isRead && !inReload) begin
            byteBuf <= engData; // [RULE7]
         end
      end
   end

   // set wins over a same-cycle software clear [RULE8]
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         timeoutFlag <= 1'b0;
         loadedFlag <= 1'b0;
      end else begin
         timeoutFlag <= timerExpired || (timeoutFlag && !clrTimeout); // [RULE1] [RULE8]
         loadedFlag <= (engDone && inReload && reloadLast) || (loadedFlag && !clrLoaded); // [RULE4]
      end
   end

   // reload starts by itself after reset, so the station address comes up loaded when the first byte matches the signature
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= sLaunch;
         busyFlag <= 1'b1;
         inReload <= 1'b1;
         idx <= 3'h0;
         stationAddr <= 48'h0;
      end else begin
         case (state)
            sIdle: if (launchSw) begin
               busyFlag <= 1'b1;
               state <= sLaunch;
               idx <= 3'h0;
               inReload <= pwdata[eeprom_cmd_pkg::CODE_MSB:eeprom_cmd_pkg::CODE_LSB]
                           == eeprom_cmd_pkg::reloadCmd;
            end
            sLaunch: state <= sRun;
            // busy clears as soon as a command's last engine run ends, polled or aborted [RULE1] [RULE2]
            sRun: if (engDone) begin
               if (inReload && idx != 3'h0) begin
                  stationAddr[8*(idx-3'h1) +: 8] <= engData; // [RULE4]
               end
               if (inReload && !reloadEnd) begin
                  idx <= idx + 3'h1;
                  state <= sLaunch;
               end else begin
                  busyFlag <= 1'b0;
                  inReload <= 1'b0;
                  state <= sIdle;
               end
            end
            default: state <= sIdle;
         endcase
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_timeout_sets_flag;
      timerExpired |=> timeoutFlag ##1 timeoutFlag || $past(clrTimeout);
   endproperty
   a_timeout_sets_flag: assert property (p_timeout_sets_flag) // [RULE1]
      else $error("time-out did not set the flag");

   property p_timeout_goes_idle;
      timerExpired |-> ##[1:3] (state == sIdle && !busyFlag);
   endproperty
   a_timeout_goes_idle: assert property (p_timeout_goes_idle) // [RULE1]
      else $error("controller not idle after time-out");

   property p_high_line_finishes;
      (engWaiting && serialDataIn && !inReload) |-> ##[1:3] !busyFlag;
   endproperty
   a_high_line_finishes: assert property (p_high_line_finishes) // [RULE2]
      else $error("busy held with data line high");

   property p_only_prog_timeout;
      timerExpired |-> !inReload && (cmdCode inside {eeprom_cmd_pkg::eraseCmd,
         eeprom_cmd_pkg::clearAllCmd, eeprom_cmd_pkg::writeCmd, eeprom_cmd_pkg::fillAllCmd});
   endproperty
   a_only_prog_timeout: assert property (p_only_prog_timeout) // [RULE3]
      else $error("non-programming command timed out");

   property p_loaded_after_reload;
      $rose(loadedFlag) |-> $past(engDone) && $past(inReload) && $past(idx) == 3'h6;
   endproperty
   a_loaded_after_reload: assert property (p_loaded_after_reload) // [RULE4]
      else $error("loaded flag set without full reload");

   property p_addr_write;
      (wrCmd && !busyFlag) |=> memAddr == $past(pwdata[7:0]);
   endproperty
   a_addr_write: assert property (p_addr_write) // [RULE5]
      else $error("byte address not written");

   property p_data_write;
      (wrData && !busyFlag) |=> byteBuf == $past(pwdata[7:0]) ##1 busyFlag || $stable(byteBuf);
   endproperty
   a_data_write: assert property (p_data_write) // [RULE7]
      else $error("byte buffer not written");

   property p_flag_sticky;
      (timeoutFlag && wrCmd && !pwdata[eeprom_cmd_pkg::TIMEOUT_BIT]) |=> timeoutFlag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) // [RULE8]
      else $error("time-out flag lost on zero write");

   // apb answer is a single-cycle pulse, never stretched
   property p_pready_pulse;
      pready |=> !pready;
   endproperty
   a_pready_pulse: assert property (p_pready_pulse)
      else $error("ready held longer than one cycle");

   property p_unmapped_error;
      (psel && penable && !pready && !hitCmd && !hitData) |=> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped_error: assert property (p_unmapped_error)
      else $error("unmapped access not flagged");

   property p_busy_start;
      launchSw |=> busyFlag && state == sLaunch;
   endproperty
   a_busy_start: assert property (p_busy_start)
      else $error("start did not raise busy");

   property p_addr_frozen;
      (wrCmd && busyFlag) |=> $stable(memAddr) && $stable(cmdCode);
   endproperty
   a_addr_frozen: assert property (p_addr_frozen) // [RULE5]
      else $error("byte address changed while busy");

   property p_data_frozen;
      (wrData && busyFlag && !engDone) |=> $stable(byteBuf);
   endproperty
   a_data_frozen: assert property (p_data_frozen) // [RULE7]
      else $error("byte buffer changed while busy");

   property p_loaded_sticky;
      (loadedFlag && !clrLoaded) |=> loadedFlag;
   endproperty
   a_loaded_sticky: assert property (p_loaded_sticky) // [RULE8]
      else $error("loaded flag lost without a clear");

   property p_timeout_clears;
      (clrTimeout && !timerExpired) |=> !timeoutFlag;
   endproperty
   a_timeout_clears: assert property (p_timeout_clears) // [RULE8]
      else $error("time-out flag not cleared by a one");

   // read, enable, disable and reload never poll, so they cannot time out
   property p_wait_only_prog;
      engWaiting |-> !inReload && needWait;
   endproperty
   a_wait_only_prog: assert property (p_wait_only_prog) // [RULE3]
      else $error("poll started for a non-programming command");

   c_reload_done: cover property ($rose(loadedFlag));
   c_timeout: cover property (timerExpired);
   c_read_done: cover property (engDone && isRead && !inReload);
   c_high_line_done: cover property (engWaiting && serialDataIn && !inReload);
   c_bad_signature: cover property (engDone && inReload && sigBad);
endmodule

/* tb/eeprom_model.sv */
// behavioural three-wire serial memory with ready polling
`timescale 1ns/1ps
module eeprom_model (
   input  wire logic                    clk,
   input  eeprom_cmd_pkg::wire_out_type pins,
   input  wire logic                    present,
   input  wire logic                    pullHigh,
   output logic                         lineLevel
);
   logic [7:0]  mem [256];
   logic [18:0] sh;
   logic [7:0]  a;
   logic        prevSk, prevCs, enabled, drive, dOut, pend, poll;
   int          n, busyLeft;
   // a line released by both controller and memory shows the pull level, never the last bit driven
   assign lineLevel = pins.serialDataOe ? pins.serialDataOut : (drive ? dOut : pullHigh);
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'h3c;
      end
      mem[0] = 8'ha5;
      {prevSk, prevCs, enabled, drive, dOut, pend, poll, sh, a} = '0;
      n = 0;
      busyLeft = 0;
   end
   // works on the falling edge so the block always samples a settled line
   always @(negedge clk) begin
      if (pins.chipSelect && !prevCs) begin
         n = 0;
         poll = pend;
         drive = pend && present;
         dOut = 1'b0;
         busyLeft = 20;
      end
      if (!pins.chipSelect && prevCs) begin
         drive = 1'b0;
         if (poll) pend = 1'b0;
         poll = 1'b0;
      end
      // slow programming: busy for a while, then ready
      if (poll && busyLeft > 0) busyLeft--;
      else if (poll) dOut = 1'b1;
      if (present && pins.chipSelect && !poll && pins.serialClock && !prevSk) begin
         sh = {sh[17:0], pins.serialDataOut};
         n++;
         if (drive && n > 11 && n < 20) dOut = mem[a][19-n];
         if (n == 11) begin
            a = sh[7:0];
            case (sh[9:8])
               2'h2: begin
                  drive = 1'b1;
                  dOut = 1'b0;
               end
               2'h3: begin
                  if (enabled) mem[a] = 8'hff;
                  pend = enabled;
               end
               2'h0: begin
                  if (a[7:6] == 2'h3) enabled = 1'b1;
                  if (a[7:6] == 2'h0) enabled = 1'b0;
                  if (a[7:6] == 2'h2 && enabled) begin
                     foreach (mem[i]) mem[i] = 8'hff;
                  end
                  if (a[7:6] == 2'h2) pend = enabled;
               end
               default: ;
            endcase
         end
         if (n == 19 && enabled) begin
            if (sh[17:16] == 2'h1) mem[sh[15:8]] = sh[7:0];
            if (sh[17:16] == 2'h0 && sh[15:14] == 2'h1) begin
               foreach (mem[i]) mem[i] = sh[7:0];
            end
            pend = (sh[17:16] == 2'h1) || (sh[17:16] == 2'h0 && sh[15:14] == 2'h1);
         end
      end
      prevSk = pins.serialClock;
      prevCs = pins.chipSelect;
   end
endmodule

/* tb/serial_eeprom_command_status_bench.sv */
// self-checking bench for the eeprom command and status block
`timescale 1ns/1ps
module serial_eeprom_command_status_bench;
   localparam int unsigned TO = 200;
   localparam logic [11:0] CMD = eeprom_cmd_pkg::CMD_OFFSET;
   localparam logic [11:0] DAT = eeprom_cmd_pkg::DATA_OFFSET;
   logic                         clk, rst_b, psel, penable, pwrite, pready, pslverr, e;
   logic                         sdi, present, pullHigh;
   logic [11:0]                  paddr;
   logic [31:0]                  pwdata, prdata, rd;
   logic [47:0]                  stationAddr;
   eeprom_cmd_pkg::wire_out_type pins;
   int                           miscompares, nChecks;

   serial_eeprom_command_status #(.TIMEOUT_CYCLES(TO), .SK_HALF(2)) i_dut (
      .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .serialDataIn(sdi), .serialPins(pins), .stationAddr(stationAddr));
   eeprom_model i_mem (.clk(clk), .pins(pins), .present(present), .pullHigh(pullHigh),
      .lineLevel(sdi));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [7:0] img(input int i);
      return (i == 0) ? 8'ha5 : (8'(i) ^ 8'h3c);
   endfunction

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      nChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer: setup, access, hold until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic idle();
      do apb(1'b0, CMD, 32'h0); while (rd[31] !== 1'b0);
   endtask

   task automatic run(input logic [2:0] c, input logic [7:0] ad);
      apb(1'b1, CMD, {1'b1, c, 20'h0, ad});
      idle();
   endtask

   task automatic rdbyte(input logic [7:0] ad, input logic [7:0] exp);
      run(eeprom_cmd_pkg::readCmd, ad);
      apb(1'b0, DAT, 32'h0);
      chk(rd, {24'h0, exp});
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", nChecks, miscompares);
      if (miscompares == 0 && nChecks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      repeat (80000) @(posedge clk);
      miscompares++;
      wrap_up();
   end

   initial begin
      {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
      {miscompares, nChecks} = '0;
      present = 1'b1;
      pullHigh = 1'b1;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      // writes during the power-up reload must be ignored
      apb(1'b1, DAT, 32'h77);
      apb(1'b1, CMD, 32'h800000ff);
      apb(1'b0, DAT, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, CMD, 32'h0);
      chk(rd[7:0], 8'h00);
      idle();
      chk(rd[9:8], 2'h1);
      chk(stationAddr, {img(6), img(5), img(4), img(3), img(2), img(1)});
      apb(1'b0, 12'hffc, 32'h0);
      chk({e, rd}, {1'b1, 32'h0});
      // status flags are write-one-to-clear
      apb(1'b1, CMD, 32'h0);
      apb(1'b0, CMD, 32'h0);
      chk(rd[8], 1'b1);
      apb(1'b1, CMD, 32'h100);
      apb(1'b0, CMD, 32'h0);
      chk(rd[8], 1'b0);
      rdbyte(8'h05, img(5));
      apb(1'b0, CMD, 32'h0);
      chk(rd[7:0], 8'h05);
      // writes before enable must leave the memory untouched
      apb(1'b1, DAT, 32'h5a);
      run(eeprom_cmd_pkg::writeCmd, 8'h20);
      rdbyte(8'h20, img(32));
      run(eeprom_cmd_pkg::eraseWriteEnableCmd, 8'h00);
      apb(1'b1, DAT, 32'h5a);
      run(eeprom_cmd_pkg::writeCmd, 8'h20);
      rdbyte(8'h20, 8'h5a);
      run(eeprom_cmd_pkg::eraseCmd, 8'h20);
      rdbyte(8'h20, 8'hff);
      apb(1'b1, DAT, 32'h33);
      run(eeprom_cmd_pkg::fillAllCmd, 8'h00);
      rdbyte(8'h80, 8'h33);
      run(eeprom_cmd_pkg::clearAllCmd, 8'h00);
      rdbyte(8'hff, 8'hff);
      run(eeprom_cmd_pkg::eraseWriteDisableCmd, 8'h00);
      apb(1'b1, DAT, 32'h12);
      run(eeprom_cmd_pkg::writeCmd, 8'h20);
      rdbyte(8'h20, 8'hff);
      apb(1'b0, CMD, 32'h0);
      chk(rd[9], 1'b0);
      // signature wiped by clear-all: reload must not mark success
      run(eeprom_cmd_pkg::reloadCmd, 8'h00);
      chk(rd[9:8], 2'h0);
      // memory absent, line pulled low
      present = 1'b0;
      pullHigh = 1'b0;
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, CMD, 32'h300);
         run(3'(c), 8'h11);
         chk(rd[9], 1'(c >= 3 && c <= 6));
      end
      run(eeprom_cmd_pkg::eraseCmd, 8'h00);
      apb(1'b1, CMD, 32'h0);
      apb(1'b0, CMD, 32'h0);
      chk(rd[9], 1'b1);
      apb(1'b1, CMD, 32'h200);
      apb(1'b0, CMD, 32'h0);
      chk(rd[9], 1'b0);
      // memory absent, line pulled high
      pullHigh = 1'b1;
      for (int c = 0; c < 8; c++) begin
         run(3'(c), 8'h11);
         chk({rd[31], rd[9]}, 2'h0);
      end
      wrap_up();
   end
endmodule
